// *** dcam_pkg.sv ***
// Constants, register map and state types for the clear and fault monitor.
// Assumes a single 100 MHz clock and a simple strobe register port.
package dcam_pkg;

    localparam int NCH  = 12;
    localparam int NIN  = 4;
    localparam int NTMP = 3;
    localparam int NALM = 11;

    // Register word indexes on the register port.
    localparam logic [6:0] A_CFG0   = 7'h00;
    localparam logic [6:0] A_CFG1   = 7'h01;
    localparam logic [6:0] A_CTRL   = 7'h02;
    localparam logic [6:0] A_FEN    = 7'h03;
    localparam logic [6:0] A_STAT   = 7'h04;
    localparam logic [6:0] A_MASKA  = 7'h05;
    localparam logic [6:0] A_MASKB  = 7'h06;
    localparam logic [6:0] A_SWCLR  = 7'h07;
    localparam logic [6:0] A_ACSRC  = 7'h08;
    localparam logic [6:0] A_ACEN   = 7'h09;
    localparam logic [6:0] A_PWR    = 7'h0a;
    localparam logic [6:0] A_SRST   = 7'h0f;
    localparam logic [4:0] G_INHI   = 5'h04;
    localparam logic [4:0] G_INLO   = 5'h05;
    localparam logic [4:0] G_INHYS  = 5'h06;
    localparam logic [4:0] G_THI    = 5'h08;
    localparam logic [4:0] G_TLO    = 5'h09;
    localparam logic [4:0] G_THYS   = 5'h0a;
    localparam logic [2:0] G_CODE   = 3'h3;

    // Field positions.
    localparam int ACSRC_IN   = 0;
    localparam int ACSRC_TMP  = 1;
    localparam int ACSRC_OVH  = 2;
    localparam int ACEN_LSB   = 3;
    localparam int B_OVH      = 10;
    localparam int B_TMP0     = 4;

    // Values after reset.
    localparam logic [2:0]  IN_CNT_RST = 3'h3;
    localparam logic [1:0]  T_CNT_RST  = 2'h2;
    localparam logic [11:0] IN_HI_RST  = 12'hfff;
    localparam logic [11:0] IN_LO_RST  = 12'h000;
    localparam logic [11:0] T_HI_RST   = 12'h7ff;
    localparam logic [11:0] T_LO_RST   = 12'h800;

    // Temperatures are signed with eight steps per degree.
    localparam int TEMP_STEP_PER_DEG = 8;
    localparam int OVH_LIMIT_DEG     = 150;
    localparam int OVH_HYS_DEG       = 8;
    localparam logic signed [13:0] OVH_LIMIT = 14'(OVH_LIMIT_DEG * TEMP_STEP_PER_DEG);
    localparam logic signed [13:0] OVH_HYS   = 14'(OVH_HYS_DEG * TEMP_STEP_PER_DEG);

    typedef struct packed {
        logic        valid;
        logic [1:0]  sel;
        logic [11:0] value;
    } dcam_conv_t;

    typedef struct packed {
        logic [2:0]               in_cnt;
        logic [1:0]               t_cnt;
        logic                     unlatch;
        logic [NALM-1:0]          fen;
        logic [NCH-1:0]           mask_a;
        logic [NCH-1:0]           mask_b;
        logic [NCH-1:0]           sw_clr;
        logic [2:0]               ac_src;
        logic [NCH-1:0]           ac_en;
        logic                     lt_pwr;
        logic [NIN-1:0][11:0]     in_hi;
        logic [NIN-1:0][11:0]     in_lo;
        logic [NIN-1:0][6:0]      in_hys;
        logic [NTMP-1:0][11:0]    t_hi;
        logic [NTMP-1:0][11:0]    t_lo;
        logic [NTMP-1:0][4:0]     t_hys;
        logic [NCH-1:0][11:0]     code;
        logic [NCH-1:0][11:0]     latch;
        logic [NCH-1:0]           clr;
        logic [NALM-1:0]          active;
        logic [NALM-1:0]          status;
        logic [NALM-1:0][8:0]     cnt;
        logic                     drive;
        logic [15:0]              rdata;
    } dcam_state_t;

    function automatic dcam_state_t dcam_rst_state();
        dcam_state_t s;
        s        = '0;
        s.in_cnt = IN_CNT_RST;
        s.t_cnt  = T_CNT_RST;
        s.lt_pwr = 1'b1;
        for (int i = 0; i < NIN; i++)
        begin
            s.in_hi[i] = IN_HI_RST;
            s.in_lo[i] = IN_LO_RST;
        end
        for (int i = 0; i < NTMP; i++)
        begin
            s.t_hi[i] = T_HI_RST;
            s.t_lo[i] = T_LO_RST;
        end
        return s;
    endfunction

endpackage

// *** dcam_monitor.sv ***
// Clear control for twelve converter latches and window fault monitor.
// Assumes conversion results arrive as one-cycle valid strobes on sys_clk.
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module dcam_monitor
    import dcam_pkg::*;
(
    input  wire logic                 sys_clk,            // System clock.
    input  wire logic                 reset,              // Asynchronous reset.
    input  wire logic [6:0]           reg_addr,           // Register index.
    input  wire logic [15:0]          reg_wdata,          // Write data.
    input  wire logic                 reg_wr,             // Write strobe.
    input  wire logic                 reg_rd,             // Read strobe.
    output logic      [15:0]          reg_rdata,          // Read data, cycle after strobe.
    input  wire logic                 hw_clear_input_a_n, // Clear pin A.
    input  wire logic                 hw_clear_input_b_n, // Clear pin B.
    input  wire dcam_conv_t           adc_conv,           // Analog input result.
    input  wire dcam_conv_t           temp_conv,          // Temperature result.
    input  wire logic [NCH-1:0][11:0] dac_data,           // Channel data registers.
    input  wire logic [NCH-1:0]       dac_load,           // Normal latch load.
    output logic      [NCH-1:0][11:0] dac_latch,          // Channel latches.
    output logic      [NCH-1:0]       channel_clear_select, // Channels in clear.
    output logic                      fault_pin_o,        // Fault pin level.
    output logic                      fault_pin_oe_n      // Fault pin enable.
);

    localparam dcam_state_t ST_RST = dcam_rst_state();

    dcam_state_t st_q;
    dcam_state_t st_d;
    logic [NCH-1:0]  clr_now;
    logic [NALM-1:0] ev;
    logic [NALM-1:0] outr;
    logic [NALM-1:0] back;
    logic            stat_rd;
    logic            ac_hit;

    function automatic logic signed [13:0] sx(input logic [11:0] v);
        return {{2{v[11]}}, v};
    endfunction

    function automatic logic [8:0] in_n(input logic [2:0] c);
        // Widen before adding so that code 7 does not wrap to a shift of zero.
        return (c == 3'h0) ? 9'h001 : 9'(9'h001 << (4'(c) + 4'h1));
    endfunction

    function automatic logic [8:0] t_n(input logic [1:0] c);
        return 9'(9'h001 << c);
    endfunction

    // Consecutive count filter; returns {active, count}.
    function automatic logic [9:0] filt(input logic act, input logic [8:0] cnt,
                                        input logic o, input logic b, input logic [8:0] n);
        logic [8:0] c1;
        c1 = cnt + 9'h001;
        if (act)
            return {~b, 9'h000};
        else if (o && (c1 >= n))
            return {1'b1, 9'h000};
        else if (o)
            return {1'b0, c1};
        else
            return 10'h000;
    endfunction

    function automatic logic [15:0] rd_mux(input dcam_state_t s, input logic [6:0] a);
        logic [15:0] r;
        r = 16'h0000;
        case (a)
            A_CFG0:  r = {15'h0000, |s.status};
            A_CFG1:  r = {11'h000, s.t_cnt, s.in_cnt};
            A_CTRL:  r = {15'h0000, s.unlatch};
            A_FEN:   r = {5'h00, s.fen};
            A_STAT:  r = {5'h00, s.status};
            A_MASKA: r = {4'h0, s.mask_a};
            A_MASKB: r = {4'h0, s.mask_b};
            A_SWCLR: r = {4'h0, s.sw_clr};
            A_ACSRC: r = {13'h0000, s.ac_src};
            A_ACEN:  r = {1'b0, s.ac_en, 3'h0};
            A_PWR:   r = {15'h0000, s.lt_pwr};
            default:
            begin
                case (a[6:2])
                    G_INHI:  r = {4'h0, s.in_hi[a[1:0]]};
                    G_INLO:  r = {4'h0, s.in_lo[a[1:0]]};
                    G_INHYS: r = {9'h000, s.in_hys[a[1:0]]};
                    G_THI:   r = (a[1:0] < 2'h3) ? {4'h0, s.t_hi[a[1:0]]} : 16'h0000;
                    G_TLO:   r = (a[1:0] < 2'h3) ? {4'h0, s.t_lo[a[1:0]]} : 16'h0000;
                    G_THYS:  r = (a[1:0] < 2'h3) ? {11'h000, s.t_hys[a[1:0]]} : 16'h0000;
                    default:
                    begin
                        if (a[6:4] == G_CODE && a[3:0] < 4'hc)
                            r = {4'h0, s.code[a[3:0]]};
                    end
                endcase
            end
        endcase
        return r;
    endfunction

    always_comb
    begin
        logic signed [13:0] v;
        logic signed [13:0] h;
        logic [9:0]         f;
        logic [1:0]         m;
        v       = 14'sh0000;
        h       = 14'sh0000;
        f       = 10'h000;
        m       = 2'h0;
        st_d    = st_q;
        ev      = '0;
        outr    = '0;
        back    = '0;
        stat_rd = reg_rd && (reg_addr == A_STAT);

        if (reg_wr)
        begin
            case (reg_addr)
                A_CFG1:  {st_d.t_cnt, st_d.in_cnt} = reg_wdata[4:0];
                A_CTRL:  st_d.unlatch = reg_wdata[0];
                A_FEN:   st_d.fen = reg_wdata[NALM-1:0];
                A_MASKA: st_d.mask_a = reg_wdata[11:0];
                A_MASKB: st_d.mask_b = reg_wdata[11:0];
                A_SWCLR: st_d.sw_clr = reg_wdata[11:0];
                A_ACSRC: st_d.ac_src = reg_wdata[2:0];
                A_ACEN:  st_d.ac_en = reg_wdata[14:ACEN_LSB];
                A_PWR:   st_d.lt_pwr = reg_wdata[0];
                default:
                begin
                    case (reg_addr[6:2])
                        G_INHI:  st_d.in_hi[reg_addr[1:0]] = reg_wdata[11:0];
                        G_INLO:  st_d.in_lo[reg_addr[1:0]] = reg_wdata[11:0];
                        G_INHYS: st_d.in_hys[reg_addr[1:0]] = reg_wdata[6:0];
                        G_THI:
                        begin
                            if (reg_addr[1:0] < 2'h3)
                                st_d.t_hi[reg_addr[1:0]] = reg_wdata[11:0];
                        end
                        G_TLO:
                        begin
                            if (reg_addr[1:0] < 2'h3)
                                st_d.t_lo[reg_addr[1:0]] = reg_wdata[11:0];
                        end
                        G_THYS:
                        begin
                            if (reg_addr[1:0] < 2'h3)
                                st_d.t_hys[reg_addr[1:0]] = reg_wdata[4:0];
                        end
                        default:
                        begin
                            if (reg_addr[6:4] == G_CODE && reg_addr[3:0] < 4'hc)
                                st_d.code[reg_addr[3:0]] = reg_wdata[11:0];
                        end
                    endcase
                end
            endcase
        end

        // Window checks on analog inputs, one bit per input.
        for (int k = 0; k < NIN; k++)
        begin
            v       = {2'b00, adc_conv.value};
            h       = {7'h00, st_q.in_hys[k]};
            ev[k]   = adc_conv.valid && (adc_conv.sel == 2'(k));
            outr[k] = (v > {2'b00, st_q.in_hi[k]}) || (v < {2'b00, st_q.in_lo[k]});
            back[k] = (v + h <= {2'b00, st_q.in_hi[k]}) && (v >= {2'b00, st_q.in_lo[k]} + h);
        end

        // Temperature monitors, high and low bits each.
        for (int t = 0; t < NTMP; t++)
        begin
            m = 2'(t);
            v = sx(temp_conv.value);
            h = 14'({9'h000, st_q.t_hys[t]} * TEMP_STEP_PER_DEG);
            ev[B_TMP0 + 2*t]     = temp_conv.valid && (temp_conv.sel == m);
            ev[B_TMP0 + 2*t + 1] = temp_conv.valid && (temp_conv.sel == m);
            outr[B_TMP0 + 2*t]   = v > sx(st_q.t_hi[t]);
            back[B_TMP0 + 2*t]   = v <= sx(st_q.t_hi[t]) - h;
            outr[B_TMP0 + 2*t+1] = v < sx(st_q.t_lo[t]);
            back[B_TMP0 + 2*t+1] = v >= sx(st_q.t_lo[t]) + h;
        end

        // Die overheat from the local monitor with fixed margin.
        v          = sx(temp_conv.value);
        ev[B_OVH]  = temp_conv.valid && (temp_conv.sel == 2'h2) && st_q.lt_pwr;
        outr[B_OVH] = v > OVH_LIMIT;
        back[B_OVH] = v <= OVH_LIMIT - OVH_HYS;

        for (int k = 0; k < NALM; k++)
        begin
            if (ev[k])
            begin
                f = filt(st_q.active[k], st_q.cnt[k], outr[k], back[k],
                         (k < NIN) ? in_n(st_q.in_cnt) : t_n(st_q.t_cnt));
                if (k == B_OVH)
                    f = filt(st_q.active[k], st_q.cnt[k], outr[k], back[k], 9'h001);
                st_d.active[k] = f[9];
                st_d.cnt[k]    = f[8:0];
            end
        end

        if (!st_d.lt_pwr)
        begin
            st_d.active[B_OVH] = 1'b0;
            st_d.cnt[B_OVH]    = 9'h000;
        end

        // A new setting beats a clearing read in the same cycle.
        if (st_d.unlatch)
            st_d.status = st_d.active;
        else
            st_d.status = (st_q.status & ~{NALM{stat_rd}}) | (st_d.active & ev);
        if (!st_d.lt_pwr)
            st_d.status[B_OVH] = 1'b0;

        st_d.drive = |(st_d.status & st_d.fen);
        st_d.rdata = reg_rd ? rd_mux(st_q, reg_addr) : 16'h0000;

        ac_hit  = (st_q.ac_src[ACSRC_OVH] && st_q.active[B_OVH] && st_q.lt_pwr)
               || (st_q.ac_src[ACSRC_IN] && |st_q.active[NIN-1:0])
               || (st_q.ac_src[ACSRC_TMP] && |st_q.active[B_OVH-1:B_TMP0]);
        clr_now = ({NCH{!hw_clear_input_a_n}} & st_q.mask_a)
                | ({NCH{!hw_clear_input_b_n}} & st_q.mask_b)
                | st_q.sw_clr
                | ({NCH{ac_hit}} & st_q.ac_en);
        st_d.clr = clr_now;
        for (int c = 0; c < NCH; c++)
        begin
            if (clr_now[c] && !st_q.clr[c])
                st_d.latch[c] = st_q.code[c];
            else if (!clr_now[c] && (st_q.clr[c] || dac_load[c]))
                st_d.latch[c] = dac_data[c];
        end

        if (reg_wr && reg_addr == A_SRST)
            st_d = ST_RST;
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            st_q <= ST_RST;
        else
            st_q <= st_d;
    end

    assign reg_rdata            = st_q.rdata;
    assign dac_latch            = st_q.latch;
    assign channel_clear_select = st_q.clr;
    assign fault_pin_o          = 1'b0;
    assign fault_pin_oe_n       = ~st_q.drive;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    sequence s_enter0;
        clr_now[0] && !st_q.clr[0] && !(reg_wr && reg_addr == A_SRST);
    endsequence

    sequence s_leave0;
        !clr_now[0] && st_q.clr[0] && !(reg_wr && reg_addr == A_SRST);
    endsequence

    chk_clear_entry_code: assert property (s_enter0 |=> dac_latch[0] == $past(st_q.code[0]))
        else $error("clear entry did not load clear code");
    chk_clear_exit_data: assert property (s_leave0 |=> dac_latch[0] == $past(dac_data[0]))
        else $error("clear exit did not reload data");
    chk_pin_a_mask: assert property (!hw_clear_input_a_n |-> ((clr_now & st_q.mask_a) == st_q.mask_a))
        else $error("pin A mask not applied");
    chk_sw_clear_sel: assert property (((clr_now & st_q.sw_clr) == st_q.sw_clr))
        else $error("software clear selection lost");
    chk_auto_clear_hit: assert property ((st_q.ac_src[ACSRC_OVH] && st_q.active[B_OVH] && st_q.lt_pwr)
        |-> ((clr_now & st_q.ac_en) == st_q.ac_en))
        else $error("overheat auto clear missing");
    chk_global_or: assert property (reg_rd && reg_addr == A_CFG0 |=> reg_rdata[0] == $past(|st_q.status))
        else $error("global flag is not OR of bits");
    chk_pin_masked: assert property (##1 fault_pin_oe_n == !(|$past(st_d.status & st_d.fen)))
        else $error("fault pin mask mismatch");
    chk_unlatch_follow: assert property (st_q.unlatch && $past(st_q.unlatch) && !$past(reg_wr)
        |-> st_q.status == st_q.active)
        else $error("unlatched status differs from condition");
    chk_read_clears: assert property (stat_rd && !st_q.unlatch && ev == '0 && !reg_wr |=> st_q.status == '0)
        else $error("status read did not clear bits");
    chk_overheat_off: assert property (!st_q.lt_pwr |-> !st_q.active[B_OVH] && !st_q.status[B_OVH])
        else $error("overheat active while sensor off");
    chk_filter_count: assert property ($rose(st_q.active[0]) && !$past(reg_wr)
        |-> $past(st_q.cnt[0]) == in_n($past(st_q.in_cnt)) - 9'h001)
        else $error("input flag set before N results");

endmodule

`default_nettype wire

// *** dcam_host_model.sv ***
// Host side model: drives both clear pins and watches the fault line.
// Assumes the fault line has a pull-up, so a released line reads high.
`timescale 1ns/1ps
`default_nettype none
module dcam_host_model (
    input  wire logic sys_clk,            // System clock.
    input  wire logic clr_a_req,          // Request clear pin A low.
    input  wire logic clr_b_req,          // Request clear pin B low.
    input  wire logic fault_pin_o,        // Pin value from the block.
    input  wire logic fault_pin_oe_n,     // Pin enable from the block.
    output logic      hw_clear_input_a_n, // Clear pin A.
    output logic      hw_clear_input_b_n, // Clear pin B.
    output logic      fault_line          // Resolved fault line level.
);
    // The pull-up wins whenever the block releases the line.
    assign fault_line = fault_pin_oe_n ? 1'h1 : fault_pin_o;
    initial
    begin
        hw_clear_input_a_n = 1'h1;
        hw_clear_input_b_n = 1'h1;
    end
    always @(posedge sys_clk)
    begin
        hw_clear_input_a_n <= ~clr_a_req;
        hw_clear_input_b_n <= ~clr_b_req;
    end
endmodule
`default_nettype wire

// *** dcam_monitor_tb.sv ***
// Self-checking bench for the clear control and fault monitor.
// Assumes the host model drives the clear pins and resolves the fault line.
`timescale 1ns/1ps
`default_nettype none
module dcam_monitor_tb;
    import dcam_pkg::*;
    typedef struct packed {
        logic [11:0] ma;
        logic [11:0] mb;
        logic [11:0] sw;
        logic        ra;
        logic        rb;
        logic [11:0] exp;
    } dcam_row_t;
    logic                 sys_clk = 1'h0;
    logic                 reset = 1'h1;
    logic [6:0]           reg_addr = '0;
    logic [15:0]          reg_wdata = '0;
    logic                 reg_wr = 1'h0;
    logic                 reg_rd = 1'h0;
    logic [15:0]          reg_rdata;
    logic                 clr_a_req = 1'h0;
    logic                 clr_b_req = 1'h0;
    logic                 pin_a_n;
    logic                 pin_b_n;
    logic                 pin_o;
    logic                 pin_oe_n;
    logic                 fault_line;
    dcam_conv_t           adc_conv = '0;
    dcam_conv_t           temp_conv = '0;
    logic [NCH-1:0][11:0] dac_data;
    logic [NCH-1:0]       dac_load = '0;
    logic [NCH-1:0][11:0] dac_latch;
    logic [NCH-1:0]       clr_sel;
    int                   miscompares = 0;
    int                   cmp_count = 0;
    int                   nin[8] = '{1, 4, 8, 16, 32, 64, 128, 256};
    int                   ntmp[4] = '{1, 2, 4, 8};
    dcam_row_t rows[6] = '{
        '{12'h00f, 12'h000, 12'h000, 1'h0, 1'h0, 12'h000},
        '{12'h00f, 12'hf00, 12'h000, 1'h1, 1'h0, 12'h00f},
        '{12'h00f, 12'hf00, 12'h000, 1'h0, 1'h1, 12'hf00},
        '{12'h00f, 12'hf00, 12'h000, 1'h1, 1'h1, 12'hf0f},
        '{12'h00f, 12'hf00, 12'h030, 1'h0, 1'h0, 12'h030},
        '{12'h000, 12'h000, 12'h000, 1'h1, 1'h1, 12'h000}};

    dcam_monitor dut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hw_clear_input_a_n(pin_a_n),
        .hw_clear_input_b_n(pin_b_n), .adc_conv(adc_conv), .temp_conv(temp_conv), .dac_data(dac_data),
        .dac_load(dac_load), .dac_latch(dac_latch), .channel_clear_select(clr_sel),
        .fault_pin_o(pin_o), .fault_pin_oe_n(pin_oe_n));
    dcam_host_model host (.sys_clk(sys_clk), .clr_a_req(clr_a_req), .clr_b_req(clr_b_req),
        .fault_pin_o(pin_o), .fault_pin_oe_n(pin_oe_n), .hw_clear_input_a_n(pin_a_n),
        .hw_clear_input_b_n(pin_b_n), .fault_line(fault_line));

    always #5 sys_clk = ~sys_clk;

    task chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("FAIL t=%0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge sys_clk);
        reg_wr <= 1'h0;
    endtask
    task rdchk(input logic [6:0] a, input logic [15:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge sys_clk);
        reg_rd <= 1'h0;
        #1;
        chk(reg_rdata, e, "register read");
    endtask
    task conv(input logic t, input logic [1:0] s, input logic [11:0] v);
        @(posedge sys_clk);
        if (t)
            temp_conv <= '{1'h1, s, v};
        else
            adc_conv <= '{1'h1, s, v};
        @(posedge sys_clk);
        temp_conv.valid <= 1'h0;
        adc_conv.valid <= 1'h0;
    endtask
    task cnt_run(input logic t, input logic [1:0] s, input logic [11:0] bad, input logic [11:0] good,
                 input int n, input logic [15:0] b);
        repeat (n - 1) conv(t, s, bad);
        rdchk(A_STAT, 16'h0000);
        conv(t, s, bad);
        rdchk(A_STAT, b);
        conv(t, s, good);
        rdchk(A_STAT, 16'h0000);
    endtask
    task stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        #600000;
        miscompares++;
        stop_test;
    end

    initial
    begin
        for (int i = 0; i < NCH; i++)
            dac_data[i] = 12'h050 + 12'(i);
        repeat (6) @(posedge sys_clk);
        reset <= 1'h0;
        rdchk(A_CFG1, 16'h0013);
        rdchk(A_PWR, 16'h0001);
        rdchk(7'h7f, 16'h0000);
        chk(16'(fault_line), 16'h0001, "idle line");
        $display("test reset done");
        @(posedge sys_clk);
        dac_load <= '1;
        @(posedge sys_clk);
        dac_load <= '0;
        for (int i = 0; i < NCH; i++)
            wr({G_CODE, 4'(i)}, 16'ha00 + 16'(i));
        for (int r = 0; r < 6; r++)
        begin
            wr(A_MASKA, {4'h0, rows[r].ma});
            wr(A_MASKB, {4'h0, rows[r].mb});
            wr(A_SWCLR, {4'h0, rows[r].sw});
            clr_a_req <= rows[r].ra;
            clr_b_req <= rows[r].rb;
            tick(3);
            chk(16'(clr_sel), 16'(rows[r].exp), "clear set");
            for (int i = 0; i < NCH; i++)
                chk(16'(dac_latch[i]), rows[r].exp[i] ? 16'ha00 + 16'(i) : 16'h050 + 16'(i), "latch");
        end
        $display("test clear table done");
        // Thresholds keep high at or above low throughout.
        wr(A_CFG1, 16'h0010);
        wr(A_CTRL, 16'h0001);
        wr({G_INHI, 2'h0}, 16'h0800);
        wr(A_ACSRC, 16'h0001);
        wr(A_ACEN, 16'h0018);
        conv(1'h0, 2'h0, 12'h900);
        rdchk(A_STAT, 16'h0001);
        rdchk(A_CFG0, 16'h0001);
        chk(16'(fault_line), 16'h0001, "masked line");
        chk(16'(clr_sel), 16'h0003, "auto clear");
        wr(A_FEN, 16'h0001);
        tick(2);
        chk(16'(fault_line), 16'h0000, "line low");
        wr({G_INHYS, 2'h0}, 16'h0010);
        conv(1'h0, 2'h0, 12'h7f1);
        rdchk(A_STAT, 16'h0001);
        conv(1'h0, 2'h0, 12'h7f0);
        rdchk(A_STAT, 16'h0000);
        chk(16'(fault_line), 16'h0001, "line released");
        chk(16'(clr_sel), 16'h0000, "auto release");
        wr(A_CTRL, 16'h0000);
        conv(1'h0, 2'h0, 12'h900);
        conv(1'h0, 2'h0, 12'h100);
        rdchk(A_STAT, 16'h0001);
        rdchk(A_STAT, 16'h0000);
        $display("test window done");
        wr(A_CTRL, 16'h0001);
        wr({G_INLO, 2'h1}, 16'h0100);
        wr({G_THI, 2'h0}, 16'h00c8);
        wr({G_TLO, 2'h1}, 16'h0000);
        for (int c = 0; c < 8; c++)
        begin
            wr(A_CFG1, 16'h0010 | 16'(c));
            cnt_run(1'h0, 2'h1, 12'h000, 12'h200, nin[c], 16'h0002);
        end
        for (int c = 0; c < 4; c++)
        begin
            wr(A_CFG1, 16'(c) << 3);
            cnt_run(1'h1, 2'h0, 12'h100, 12'h000, ntmp[c], 16'h0010);
            cnt_run(1'h1, 2'h1, 12'hff0, 12'h010, ntmp[c], 16'h0080);
        end
        $display("test counts done");
        wr(A_ACSRC, 16'h0004);
        wr(A_ACEN, 16'h0008);
        conv(1'h1, 2'h2, 12'h4b1);
        rdchk(A_STAT, 16'h0400);
        chk(16'(clr_sel), 16'h0001, "overheat clear");
        conv(1'h1, 2'h2, 12'h471);
        rdchk(A_STAT, 16'h0400);
        conv(1'h1, 2'h2, 12'h470);
        rdchk(A_STAT, 16'h0000);
        wr(A_PWR, 16'h0000);
        conv(1'h1, 2'h2, 12'h4b1);
        rdchk(A_STAT, 16'h0000);
        chk(16'(clr_sel), 16'h0000, "sensor off");
        $display("test overheat done");
        wr(A_CTRL, 16'h0000);
        wr(A_CFG1, 16'h0000);
        wr({G_INLO, 2'h0}, 16'h0100);
        conv(1'h0, 2'h0, 12'h000);
        wr(A_SRST, 16'h0000);
        rdchk(A_STAT, 16'h0000);
        rdchk(A_CFG1, 16'h0013);
        wr(A_CFG1, 16'h0000);
        wr({G_INLO, 2'h0}, 16'h0100);
        wr(A_FEN, 16'h0001);
        conv(1'h0, 2'h0, 12'h000);
        tick(2);
        chk(16'(fault_line), 16'h0000, "set before reset");
        reset <= 1'h1;
        tick(2);
        reset <= 1'h0;
        chk(16'(fault_line), 16'h0001, "line after reset");
        rdchk(A_STAT, 16'h0000);
        $display("test resets done");
        stop_test;
    end
endmodule
`default_nettype wire
